// file: hdl/rifs_top.v
// Secondary interrupt, FIFO status and receive control registers on APB.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "rifs_defs.vh"
module rifs_top (
    input  wire                   clk_in,
    input  wire                   rst_b_in,
    input  wire                   chip_en_in,

    // APB slave.
    input  wire                   psel_in,
    input  wire                   penable_in,
    input  wire                   pwrite_in,
    input  wire [`RIFS_ADDR_W-1:0] paddr_in,
    input  wire [31:0]            pwdata_in,
    output wire                   pready_out,
    output reg  [31:0]            prdata_out,
    output wire                   pslverr_out,

    // Analog status levels.
    input  wire                   osc_good_in,
    input  wire                   synth_lock_in,
    input  wire                   field_good_in,

    // Event pulses from the command and receive engines.
    input  wire                   cmd_done_in,
    input  wire                   crc_fail_in,
    input  wire                   rx_short_in,
    input  wire                   protocol_fault_in,
    input  wire                   preamble_fail_in,

    // FIFO and activity state.
    input  wire                   tx_busy_in,
    input  wire                   rx_busy_in,
    input  wire [4:0]             fifo_level_in,
    input  wire                   fifo_load_in,
    input  wire                   fifo_empty_read_in,

    // Receive framing.
    input  wire                   rx_start_in,
    input  wire                   rx_byte_in,
    input  wire                   header_valid_in,
    input  wire                   header_bit_in,
    input  wire [7:0]             rx_len_low_in,

    // First interrupt register, held elsewhere.
    input  wire                   irq1_pending_in,

    // Outputs.
    output wire                   irq_out,
    output reg                    error_event_out,
    output wire                   header_event_out,
    output wire [11:0]            expected_rx_len_out,
    output wire                   skip_receive_check_out,
    output wire                   raw_queue_second_byte_mode_out
);

    // Register storage.
    reg  [7:0]  status_ff;
    reg  [7:0]  mask_ff;
    reg  [7:0]  rxctrl_ff;
    reg         ovf_ff;
    reg         empty_rd_ff;

    // Next values.
    reg  [7:0]  nxt_status;
    reg         nxt_ovf;
    reg         nxt_empty_rd;
    reg  [31:0] nxt_prdata;

    // Decode and event wires.
    wire [7:0]  idx;
    wire        hit_mask;
    wire        hit_status;
    wire        hit_fifo;
    wire        hit_rxctrl;
    wire        mapped;
    wire        setup_rd;
    wire        access;
    wire        wr_done;
    wire        rd_done;
    wire        ana_evt;
    wire        crc_evt;
    wire        len_evt;
    wire        ovf_evt;
    wire        pre_evt;
    wire [7:0]  set_vec;
    wire [7:0]  clr_vec;
    wire [7:0]  fifo_view;
    wire [4:0]  count_view;

    // Control bits used by the interrupt and receive paths.
    wire        crc_fault_unmask;
    wire        length_fault_unmask;
    wire        preamble_fault_unmask;
    wire        repeat_byte_pair_interrupt;
    wire        auto_len;

    // Byte address is four times the register index.
    assign idx        = paddr_in[`RIFS_ADDR_W-1:2];

    // Address decoding, one compare per register.
    assign hit_mask   = (idx == `RIFS_IDX_MASK);
    assign hit_status = (idx == `RIFS_IDX_STATUS);
    assign hit_fifo   = (idx == `RIFS_IDX_FIFO);
    assign hit_rxctrl = (idx == `RIFS_IDX_RXCTRL);
    assign mapped     = hit_mask | hit_status | hit_fifo | hit_rxctrl;

    // Phases of an APB transfer. The slave never inserts wait states, so
    // every access phase completes on its first edge.
    assign setup_rd   = psel_in & ~penable_in & ~pwrite_in;
    assign access     = psel_in & penable_in;
    assign wr_done    = access & pwrite_in & mapped;
    assign rd_done    = access & ~pwrite_in & mapped;
    assign pready_out  = 1'b1;
    assign pslverr_out = access & ~mapped;

    // Named views of the control registers.
    assign crc_fault_unmask      = mask_ff[`RIFS_BIT_CRC];
    assign length_fault_unmask   = mask_ff[`RIFS_BIT_LEN];
    assign preamble_fault_unmask = mask_ff[`RIFS_BIT_PRE];
    assign skip_receive_check_out = rxctrl_ff[`RIFS_BIT_NOCRC];
    assign raw_queue_second_byte_mode_out =
               rxctrl_ff[`RIFS_BIT_RAW2ND];
    assign repeat_byte_pair_interrupt = rxctrl_ff[`RIFS_BIT_REP];
    assign auto_len = rxctrl_ff[`RIFS_BIT_AUTOLEN];

    // Any change of the three analog health levels, either direction.
    rifs_edge_catch #(
        .N        (3)
    ) u_edge (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .lvl_in   ({osc_good_in, synth_lock_in, field_good_in}),
        .edge_out (ana_evt)
    );

    // Receive framing helper; the extra byte interrupts and the header
    // interrupt both leave as one event towards the first register.
    rifs_rx_ctrl u_rx (
        .clk_in          (clk_in),
        .rst_b_in        (rst_b_in),
        .rx_start_in     (rx_start_in),
        .rx_byte_in      (rx_byte_in),
        .header_valid_in (header_valid_in),
        .header_bit_in   (header_bit_in),
        .raw_mode_in     (raw_queue_second_byte_mode_out),
        .rep_mode_in     (repeat_byte_pair_interrupt),
        .auto_len_in     (auto_len),
        .len_prog_in     ({rxctrl_ff[3:0], rx_len_low_in}),
        .header_evt_out  (header_event_out),
        .exp_len_out     (expected_rx_len_out)
    );

    // Error sources. A CRC failure is ignored while checking is switched
    // off, so a frame received without CRC never raises a false error.
    assign crc_evt = crc_fail_in & ~skip_receive_check_out;
    assign len_evt = rx_short_in | protocol_fault_in;

    // Loading one more byte into a full FIFO is the overflow case.
    assign ovf_evt = fifo_load_in
                   & (fifo_level_in >= `RIFS_FIFO_DEPTH);
    assign pre_evt = preamble_fail_in | ovf_evt;

    // Events that set status bits; unused bits never set.
    assign set_vec = {ana_evt, cmd_done_in, 3'b000,
                      crc_evt, len_evt, pre_evt};

    // Only the bits that were returned by the read are cleared. A bit set
    // between the setup and access edges was not seen and must survive.
    assign clr_vec = (rd_done & hit_status) ? prdata_out[7:0] : 8'h00;

    // Status next value; set wins over the read clear.
    always @* begin
        if (!chip_en_in) begin
            nxt_status = `RIFS_STATUS_RST;
        end else begin
            nxt_status = (status_ff & ~clr_vec) | set_vec;
        end
    end

    // Overflow stays until software has read it from the FIFO status.
    always @* begin
        nxt_ovf = ovf_ff;
        if (rd_done & hit_fifo & prdata_out[`RIFS_BIT_OVF]) begin
            nxt_ovf = 1'b0;
        end
        if (ovf_evt) begin
            nxt_ovf = 1'b1;
        end
    end

    // Reading an empty FIFO marks the count field until a new byte lands.
    always @* begin
        nxt_empty_rd = empty_rd_ff;
        if (fifo_load_in) begin
            nxt_empty_rd = 1'b0;
        end else if (fifo_empty_read_in & (fifo_level_in == 5'h00)) begin
            nxt_empty_rd = 1'b1;
        end
    end

    // FIFO status view.
    assign count_view = empty_rd_ff ? `RIFS_EMPTY_SHOW
                                    : fifo_level_in;
    assign fifo_view  = {tx_busy_in, rx_busy_in, ovf_ff, count_view};

    // Read data is taken in the setup phase so that it comes from a flop
    // and stands stable through the access phase.
    always @* begin
        nxt_prdata = prdata_out;
        if (setup_rd) begin
            if (hit_status) begin
                nxt_prdata = {24'h000000, status_ff};
            end else if (hit_fifo) begin
                nxt_prdata = {24'h000000, fifo_view};
            end else if (hit_mask) begin
                nxt_prdata = {24'h000000, mask_ff};
            end else if (hit_rxctrl) begin
                nxt_prdata = {24'h000000, rxctrl_ff};
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    // Status, FIFO flags and read data.
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            status_ff   <= `RIFS_STATUS_RST;
            ovf_ff      <= 1'b0;
            empty_rd_ff <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else begin
            status_ff   <= nxt_status;
            ovf_ff      <= nxt_ovf;
            empty_rd_ff <= nxt_empty_rd;
            prdata_out  <= nxt_prdata;
        end
    end

    // Software writable registers. The receive control byte may be
    // rewritten mid frame, which is how the extra byte interrupts stop.
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            mask_ff   <= `RIFS_MASK_RST;
            rxctrl_ff <= `RIFS_RXCTRL_RST;
        end else if (wr_done) begin
            if (hit_mask) begin
                mask_ff <= pwdata_in[7:0] & `RIFS_MASK_WBITS;
            end else if (hit_rxctrl) begin
                rxctrl_ff <= pwdata_in[7:0];
            end
        end
    end

    // Every error source also pulses the summary error of the first
    // register, whatever the sub-flag enables say.
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            error_event_out <= 1'b0;
        end else begin
            error_event_out <= crc_evt | len_evt | pre_evt;
        end
    end

    // Level interrupt. Sub-flag enables stay off in inventory rounds so
    // that one read of the first register releases the line.
    assign irq_out = irq1_pending_in
                   | (status_ff[`RIFS_BIT_ANA] & mask_ff[`RIFS_BIT_ANA])
                   | (status_ff[`RIFS_BIT_CMD] & mask_ff[`RIFS_BIT_CMD])
                   | (status_ff[`RIFS_BIT_CRC] & crc_fault_unmask)
                   | (status_ff[`RIFS_BIT_LEN] & length_fault_unmask)
                   | (status_ff[`RIFS_BIT_PRE]
                      & preamble_fault_unmask);

endmodule

// file: hdl/rifs_defs.vh
// Constants and functional notes for the reader status and interrupt block.
// Functional notes
// - Bit 7 sets on any edge of oscillator, synthesizer lock or field good.
// - Bit 6 sets when a direct command finishes executing.
// - Bit 2 flags CRC failure; bit 1 flags short reception or protocol fault.
// - Bit 0 flags preamble failure or FIFO overflow in receive or send.
// - Interrupt status reads zero after power up and while enable is low.
// - A completed host read clears interrupt status and its pending interrupt.
// - Interrupt is high while an enabled bit of either status register is set.
// - Every error source drives both the summary error flag and its sub-flag.
// - FIFO status bit 7 shows transmit busy, bit 6 shows receive busy.
// - FIFO status bit 5 sets when more than 24 bytes were loaded.
// - Low five bits count unread bytes; 1Fh after reading an empty FIFO.
// - Control bit 7 set suppresses CRC checking of received frames.
// - Control bit 6 passes CRC bytes; header interrupt becomes second-byte.
// - Control bit 5 adds interrupts after bytes 4 and 6; host may clear it.
// - Control bit 4 and header bit high switch expected length to 41 bits.
// - Expected length in bits: upper nibble here, low byte in next register.
// - Header interrupt fires when a received reply has its header bit high.
`ifndef RIFS_DEFS_VH
`define RIFS_DEFS_VH

// Register indices; the byte address is four times the index.
`define RIFS_IDX_MASK      8'h36
`define RIFS_IDX_STATUS    8'h38
`define RIFS_IDX_FIFO      8'h39
`define RIFS_IDX_RXCTRL    8'h3a
`define RIFS_ADDR_W        10

// Reset values and writable bits.
`define RIFS_MASK_RST      8'h40
`define RIFS_MASK_WBITS    8'hc7
`define RIFS_STATUS_RST    8'h00
`define RIFS_RXCTRL_RST    8'h00

// Field positions.
`define RIFS_BIT_ANA       7
`define RIFS_BIT_CMD       6
`define RIFS_BIT_CRC       2
`define RIFS_BIT_LEN       1
`define RIFS_BIT_PRE       0
`define RIFS_BIT_TXBUSY    7
`define RIFS_BIT_RXBUSY    6
`define RIFS_BIT_OVF       5
`define RIFS_BIT_NOCRC     7
`define RIFS_BIT_RAW2ND    6
`define RIFS_BIT_REP       5
`define RIFS_BIT_AUTOLEN   4

// Counts.
`define RIFS_FIFO_DEPTH    5'h18
`define RIFS_EMPTY_SHOW    5'h1f
`define RIFS_ERRCODE_LEN   12'h029

`endif

// file: hdl/rifs_edge_catch.v
// Any-edge detector over a group of status levels.
`timescale 1ns/100ps
`include "rifs_defs.vh"
module rifs_edge_catch #(
    parameter N = 3
) (
    input  wire         clk_in,
    input  wire         rst_b_in,
    input  wire [N-1:0] lvl_in,
    output reg          edge_out
);
    reg  [N-1:0] prev_ff;
    reg          primed_ff;
    wire [N-1:0] diff;

    // One comparator per level; the first cycle after reset only loads the
    // history so a level that is already high raises no false event.
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            assign diff[i] = primed_ff & (prev_ff[i] ^ lvl_in[i]);
        end
    endgenerate

    // History and one-cycle event pulse.
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            prev_ff   <= {N{1'b0}};
            primed_ff <= 1'b0;
            edge_out  <= 1'b0;
        end else begin
            prev_ff   <= lvl_in;
            primed_ff <= 1'b1;
            edge_out  <= |diff;
        end
    end
endmodule

// file: hdl/rifs_rx_ctrl.v
// Receive byte counting, header interrupt and expected length selection.
`timescale 1ns/100ps
`include "rifs_defs.vh"
module rifs_rx_ctrl (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        rx_start_in,
    input  wire        rx_byte_in,
    input  wire        header_valid_in,
    input  wire        header_bit_in,
    input  wire        raw_mode_in,
    input  wire        rep_mode_in,
    input  wire        auto_len_in,
    input  wire [11:0] len_prog_in,
    output reg         header_evt_out,
    output reg  [11:0] exp_len_out
);
    reg  [2:0] cnt_ff;
    reg        errlen_ff;
    wire [2:0] nxt_cnt;
    wire       byte_evt;
    wire       hdr_evt;

    // Counter saturates at seven; only bytes two, four and six matter.
    assign nxt_cnt = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
    assign byte_evt = rx_byte_in
                    & ((raw_mode_in & nxt_cnt == 3'h2)
                       | (rep_mode_in
                          & (nxt_cnt == 3'h4 | nxt_cnt == 3'h6)));
    assign hdr_evt = ~raw_mode_in & header_valid_in & header_bit_in;

    // Frame state; a new reception drops the error code length.
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_ff         <= 3'h0;
            errlen_ff      <= 1'b0;
            header_evt_out <= 1'b0;
            exp_len_out    <= 12'h000;
        end else begin
            if (rx_start_in) begin
                cnt_ff <= 3'h0;
            end else if (rx_byte_in) begin
                cnt_ff <= nxt_cnt;
            end
            if (rx_start_in) begin
                errlen_ff <= 1'b0;
            end else if (auto_len_in & header_valid_in & header_bit_in) begin
                errlen_ff <= 1'b1;
            end
            header_evt_out <= byte_evt | hdr_evt;
            exp_len_out    <= errlen_ff ? `RIFS_ERRCODE_LEN
                                        : len_prog_in;
        end
    end
endmodule

// file: dv/rifs_checker.sv
// Port-level assertions for the status and interrupt block.
`timescale 1ns/100ps
`include "rifs_defs.vh"
module rifs_checker (
    input wire                    clk_in,
    input wire                    rst_b_in,
    input wire                    chip_en_in,
    input wire                    psel_in,
    input wire                    penable_in,
    input wire                    pwrite_in,
    input wire [`RIFS_ADDR_W-1:0] paddr_in,
    input wire [31:0]             pwdata_in,
    input wire                    cmd_done_in,
    input wire                    crc_fail_in,
    input wire                    rx_short_in,
    input wire                    protocol_fault_in,
    input wire                    preamble_fail_in,
    input wire [4:0]              fifo_level_in,
    input wire                    fifo_load_in,
    input wire                    header_valid_in,
    input wire                    header_bit_in,
    input wire [7:0]              rx_len_low_in,
    input wire                    irq1_pending_in,
    input wire                    irq_out,
    input wire                    error_event_out,
    input wire                    header_event_out,
    input wire [11:0]             expected_rx_len_out,
    input wire                    skip_receive_check_out,
    input wire                    raw_queue_second_byte_mode_out
);
    logic wr_ctrl;
    logic cmd_en_ff;
    assign wr_ctrl = psel_in && penable_in && pwrite_in &&
                     paddr_in[9:2] == `RIFS_IDX_RXCTRL;
    // Mirror of the command enable, so the check follows mask writes.
    always @(posedge clk_in) begin
        if (!rst_b_in)
            cmd_en_ff <= 1'b1;
        else if (psel_in && penable_in && pwrite_in &&
                 paddr_in[9:2] == `RIFS_IDX_MASK)
            cmd_en_ff <= pwdata_in[`RIFS_BIT_CMD];
    end
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_err_pulse: assert property (
        chip_en_in && (rx_short_in || protocol_fault_in ||
        preamble_fail_in) |=> error_event_out)
        else $error("error pulse missing");
    a_err_cause: assert property (
        error_event_out |-> $past(rx_short_in || protocol_fault_in ||
        preamble_fail_in || (crc_fail_in && !skip_receive_check_out) ||
        (fifo_load_in && fifo_level_in >= 5'h18)))
        else $error("error pulse without cause");
    a_irq_first: assert property (
        irq1_pending_in |-> irq_out)
        else $error("irq low with first register pending");
    a_cmd_irq: assert property (
        chip_en_in && cmd_done_in && cmd_en_ff |=> irq_out)
        else $error("irq missing after command done");
    a_ctrl_hold: assert property (
        !wr_ctrl |=> $stable(skip_receive_check_out) &&
        $stable(raw_queue_second_byte_mode_out))
        else $error("control output moved without write");
    a_ctrl_write: assert property (
        wr_ctrl |=> skip_receive_check_out == $past(pwdata_in[7]) &&
        raw_queue_second_byte_mode_out == $past(pwdata_in[6]))
        else $error("control outputs do not follow write");
    a_header_evt: assert property (
        header_valid_in && header_bit_in &&
        !raw_queue_second_byte_mode_out |=> header_event_out)
        else $error("header event missing");
    a_len_low: assert property (
        $stable(rx_len_low_in) [*3] |->
        expected_rx_len_out[7:0] == rx_len_low_in ||
        expected_rx_len_out == `RIFS_ERRCODE_LEN)
        else $error("expected length low byte wrong");
endmodule
bind rifs_top rifs_checker chk_u (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .chip_en_in(chip_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .cmd_done_in(cmd_done_in), .crc_fail_in(crc_fail_in),
    .rx_short_in(rx_short_in), .protocol_fault_in(protocol_fault_in),
    .preamble_fail_in(preamble_fail_in), .fifo_level_in(fifo_level_in),
    .fifo_load_in(fifo_load_in), .header_valid_in(header_valid_in),
    .header_bit_in(header_bit_in), .rx_len_low_in(rx_len_low_in),
    .irq1_pending_in(irq1_pending_in), .irq_out(irq_out),
    .error_event_out(error_event_out),
    .header_event_out(header_event_out),
    .expected_rx_len_out(expected_rx_len_out),
    .skip_receive_check_out(skip_receive_check_out),
    .raw_queue_second_byte_mode_out(raw_queue_second_byte_mode_out));

// file: dv/rifs_host.sv
// Host controller model: an APB master serving the status block.
`timescale 1ns/100ps
module rifs_host (
    input  wire         clk_in,
    input  wire         pready_in,
    output logic        psel_out,
    output logic        penable_out,
    output logic        pwrite_out,
    output logic [9:0]  paddr_out,
    output logic [31:0] pwdata_out
);
    int timeouts = 0;
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 10'h0;
        pwdata_out = 32'h0;
    end
    // One transfer; released lines flip so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] d);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= w;
        paddr_out <= {idx, 2'b00};
        pwdata_out <= {24'h0, d};
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!pready_in && n < 50);
        if (!pready_in) timeouts++;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~{idx, 2'b00};
        pwdata_out <= ~{24'h0, d};
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the status and interrupt block.
`timescale 1ns/100ps
`include "rifs_defs.vh"
module testbench;
    logic        clk_in, rst_b_in, chip_en_in, psel, penable, pwrite;
    logic        pready, irq, err_ev, hdr_ev, skip, raw, fgood, irq1;
    logic        tx_busy, rx_busy, hdr_bit, slverr, osc, synth;
    logic [9:0]  paddr, ev;
    logic [31:0] pwdata, prdata;
    logic [4:0]  lvl;
    logic [7:0]  len_low;
    logic [3:0]  nib;
    logic [11:0] exp_len;
    logic [31:0] exp_q[$];
    int          seed, mismatches = 0, n_checks = 0;
    localparam logic [9:0] E_CMD = 10'h001, E_CRC = 10'h002,
        E_LOAD = 10'h020, E_ERD = 10'h040, E_START = 10'h080,
        E_BYTE = 10'h100, E_HDR = 10'h200;
    rifs_host host_u (.clk_in(clk_in), .pready_in(pready),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata));
    rifs_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .chip_en_in(chip_en_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(slverr),
        .osc_good_in(osc), .synth_lock_in(synth), .field_good_in(fgood),
        .cmd_done_in(ev[0]), .crc_fail_in(ev[1]), .rx_short_in(ev[2]),
        .protocol_fault_in(ev[3]), .preamble_fail_in(ev[4]),
        .tx_busy_in(tx_busy), .rx_busy_in(rx_busy), .fifo_level_in(lvl),
        .fifo_load_in(ev[5]), .fifo_empty_read_in(ev[6]),
        .rx_start_in(ev[7]), .rx_byte_in(ev[8]),
        .header_valid_in(ev[9]), .header_bit_in(hdr_bit),
        .rx_len_low_in(len_low), .irq1_pending_in(irq1),
        .irq_out(irq), .error_event_out(err_ev),
        .header_event_out(hdr_ev), .expected_rx_len_out(exp_len),
        .skip_receive_check_out(skip),
        .raw_queue_second_byte_mode_out(raw));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back({24'h0, exp});
        host_u.xfer(1'b0, idx, 8'h00);
    endtask
    // Event inputs stand for exactly one cycle, then outputs settle.
    task automatic pulse(input logic [9:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 10'h0;
        #1;
    endtask
    task automatic summarize;
        mismatches += host_u.timeouts + exp_q.size();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Each completed read takes the oldest expected value off the queue.
    // Only the four mapped indices may answer without an error.
    always @(posedge clk_in) begin
        if (psel && penable && pready)
            chk(slverr, 32'(!(paddr[9:2] inside {`RIFS_IDX_MASK,
                `RIFS_IDX_STATUS, `RIFS_IDX_FIFO, `RIFS_IDX_RXCTRL})));
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0)
                mismatches++;
            else
                chk(prdata, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    initial begin
        seed = 65201;
        {rst_b_in, ev, tx_busy, rx_busy, lvl, hdr_bit, irq1} = '0;
        {chip_en_in, fgood, osc, synth} = 4'hf;
        len_low = $random(seed);
        nib = $random(seed);
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(`RIFS_IDX_STATUS, 8'h00);
        rd(`RIFS_IDX_RXCTRL, 8'h00);
        rd(8'h10, 8'h00);
        pulse(E_CMD);
        chk(irq, 32'h1);
        rd(`RIFS_IDX_STATUS, 8'h40);
        #1 chk(irq, 32'h0);
        @(posedge clk_in) irq1 <= 1'b1;
        #1 chk(irq, 32'h1);
        @(posedge clk_in) irq1 <= 1'b0;
        // Error sources stay masked by default, so the line stays low.
        for (int i = 1; i < 5; i++) begin
            pulse(10'h1 << i);
            chk(err_ev, 32'h1);
            chk(irq, 32'h0);
            rd(`RIFS_IDX_STATUS,
               i == 1 ? 8'h04 : i == 4 ? 8'h01 : 8'h02);
        end
        host_u.xfer(1'b1, `RIFS_IDX_MASK, 8'hff);
        rd(`RIFS_IDX_MASK, 8'hc7);
        // Each health level falls and later rises again.
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            {osc, synth, fgood} <= {osc, synth, fgood} ^ 3'(1 << (i % 3));
            pulse(i == 0 ? 10'h017 : 10'h000);
            repeat (2) @(posedge clk_in);
            #1 chk(irq, 32'h1);
            rd(`RIFS_IDX_STATUS, i == 0 ? 8'hc7 : 8'h80);
            #1 chk(irq, 32'h0);
        end
        pulse(E_CMD);
        @(posedge clk_in) chip_en_in <= 1'b0;
        @(posedge clk_in) chip_en_in <= 1'b1;
        rd(`RIFS_IDX_STATUS, 8'h00);
        @(posedge clk_in) tx_busy <= 1'b1;
        lvl <= 5'({$random(seed)} % 24);
        @(posedge clk_in);
        rd(`RIFS_IDX_FIFO, {3'b100, lvl});
        @(posedge clk_in) {tx_busy, rx_busy, lvl} <= 7'h20;
        pulse(E_ERD);
        rd(`RIFS_IDX_FIFO, 8'h5f);
        @(posedge clk_in) lvl <= `RIFS_FIFO_DEPTH;
        pulse(E_LOAD);
        rd(`RIFS_IDX_STATUS, 8'h01);
        rd(`RIFS_IDX_FIFO, 8'h78);
        rd(`RIFS_IDX_FIFO, 8'h58);
        host_u.xfer(1'b1, `RIFS_IDX_RXCTRL, {4'h8, nib});
        rd(`RIFS_IDX_RXCTRL, {4'h8, nib});
        pulse(E_CRC);
        chk(err_ev, 32'h0);
        rd(`RIFS_IDX_STATUS, 8'h00);
        // Byte interrupts: repeat mode, raw mode, repeat cleared midway.
        for (int j = 0; j < 3; j++) begin
            host_u.xfer(1'b1, `RIFS_IDX_RXCTRL, j == 1 ? 8'h40 : 8'h20);
            pulse(E_START);
            for (int n = 1; n < 7; n++) begin
                if (j == 2 && n == 5)
                    host_u.xfer(1'b1, `RIFS_IDX_RXCTRL, 8'h00);
                pulse(E_BYTE);
                chk(hdr_ev, 32'(j == 1 ? n == 2
                    : n == 4 || n == 6 && j == 0));
            end
        end
        host_u.xfer(1'b1, `RIFS_IDX_RXCTRL, {4'h1, nib});
        pulse(E_START);
        @(posedge clk_in) hdr_bit <= 1'b1;
        pulse(E_HDR);
        chk(hdr_ev, 32'h1);
        @(posedge clk_in);
        #1 chk(exp_len, 32'h29);
        pulse(E_START);
        repeat (2) @(posedge clk_in);
        #1 chk(exp_len, {20'h0, nib, len_low});
        summarize();
    end
endmodule
